// ---- core/ltb_defines.svh ----
// Register map, field positions, reset values and timing counts
`ifndef LTB_DEFINES_SVH
`define LTB_DEFINES_SVH
`define LTB_OFS_CTRL 8'h00
`define LTB_OFS_PAT 8'h04
`define LTB_OFS_WIDTH 8'h08
`define LTB_OFS_UP1 8'h0C
`define LTB_OFS_LO1 8'h10
`define LTB_OFS_UP2 8'h14
`define LTB_OFS_LO2 8'h18
`define LTB_OFS_STAT 8'h1C
`define LTB_OFS_IRQ 8'h20
`define LTB_OFS_MASK 8'h24
`define LTB_C_EN1 0
`define LTB_C_EN2 1
`define LTB_C_AUTO 2
`define LTB_C_SCLR 3
`define LTB_C_ARM 4
`define LTB_C_L4 6
`define LTB_C_RUN 8
`define LTB_C_CLRNOW 9
`define LTB_C_INIT 10
`define LTB_P_PASS 0
`define LTB_P_IDLE 1
`define LTB_P_F1U 2
`define LTB_P_F1L 3
`define LTB_P_F2U 4
`define LTB_P_F2L 5
`define LTB_ARM_IMM 2'h0
`define LTB_ARM_HIGH 2'h1
`define LTB_ARM_LOW 2'h2
`define LTB_L4_EOT 2'h0
`define LTB_L4_BUSY 2'h1
`define LTB_L4_NBUSY 2'h2
`define LTB_I_DONE 0
`define LTB_I_FAIL 1
`define LTB_I_CLR 2
`define LTB_PAT_RST 24'hFF_FF00
`define LTB_WIDTH_RST 23'h00_000A
`define LTB_UP_RST 32'h0001_0000
`define LTB_LO_RST 32'hFFFF_0000
`define LTB_CLK_MHZ 100
`define LTB_STEP_US 10
`define LTB_MAX_WIDTH_S 60
`define LTB_STEP_CYCLES (`LTB_STEP_US * `LTB_CLK_MHZ)
`define LTB_MAX_STEPS (`LTB_MAX_WIDTH_S * 1000000 / `LTB_STEP_US)
`endif

// ---- core/ltb_pkg.sv ----
// Types shared by the binning output block
`default_nettype none
package ltb_pkg;
  typedef logic [3:0] ltb_pat_t;
  typedef logic signed [31:0] ltb_val_t;
  typedef enum logic [2:0] {
    S_IDLE, S_WAIT, S_PRE, S_HOLD, S_POST
  } ltb_state_e;
endpackage
`default_nettype wire

// ---- core/ltb_if.sv ----
// Links between the controller, the limit checker and the step timer
`timescale 1ns/1ps
`default_nettype none
interface ltb_if;
  import ltb_pkg::*;
  ltb_val_t reading;
  ltb_val_t up1, lo1, up2, lo2;
  logic en1, en2;
  logic [23:0] pats;
  ltb_pat_t verdict;
  logic fail1, fail2;
  logic load;
  logic [22:0] steps;
  logic done;
  modport cmp(input reading, up1, lo1, up2, lo2, en1, en2, pats,
    output verdict, fail1, fail2);
  modport tmr(input load, steps, output done);
endinterface
`default_nettype wire

// ---- core/ltb_limit_check.sv ----
// Two-limit comparison and output pattern selection
`timescale 1ns/1ps
`default_nettype none
`include "ltb_defines.svh"
module ltb_limit_check (
  // Comparison link
  ltb_if.cmp lk
);
  import ltb_pkg::*;
  logic hi1, lo1, hi2, lo2;
  always_comb begin
    hi1 = lk.en1 && (lk.reading > lk.up1);
    lo1 = lk.en1 && (lk.reading < lk.lo1);
    hi2 = lk.en2 && (lk.reading > lk.up2);
    lo2 = lk.en2 && (lk.reading < lk.lo2);
    lk.fail1 = hi1 | lo1;
    lk.fail2 = hi2 | lo2;
    if (hi1) begin
      lk.verdict = lk.pats[`LTB_P_F1U*4 +: 4];
    end else if (lo1) begin
      lk.verdict = lk.pats[`LTB_P_F1L*4 +: 4];
    end else if (hi2) begin
      lk.verdict = lk.pats[`LTB_P_F2U*4 +: 4];
    end else if (lo2) begin
      lk.verdict = lk.pats[`LTB_P_F2L*4 +: 4];
    end else begin
      lk.verdict = lk.pats[`LTB_P_PASS*4 +: 4];
    end
  end
endmodule
`default_nettype wire

// ---- core/ltb_step_timer.sv ----
// Counts whole 10 us steps and pulses done when they run out
`timescale 1ns/1ps
`default_nettype none
`include "ltb_defines.svh"
module ltb_step_timer #(
  parameter int STEP_CYCLES = `LTB_STEP_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Timer link
  ltb_if.tmr tm
);
  import ltb_pkg::*;
  localparam int PW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  typedef struct packed {
    logic run;
    logic done;
    logic [PW-1:0] pre;
    logic [22:0] cnt;
  } ltb_tmr_s;
  ltb_tmr_s s, n;
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (tm.load) begin
      n.run = 1'b1;
      n.cnt = tm.steps;
      n.pre = '0;
    end else if (s.run) begin
      if (s.cnt == 23'h00_0000) begin
        n.run = 1'b0;
        n.done = 1'b1;
      end else if (s.pre == PW'(STEP_CYCLES - 1)) begin
        n.pre = '0;
        n.cnt = s.cnt - 23'h00_0001;
      end else begin
        n.pre = s.pre + PW'(1);
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign tm.done = s.done;
  a_done_single: assert property (@(posedge mclk) disable iff (sys_rst)
    s.done |=> !s.done) else $error("timer done longer than one cycle");
  a_zero_steps: assert property (@(posedge mclk) disable iff (sys_rst)
    tm.load && tm.steps == 23'h00_0000 |=> ##1 s.done)
    else $error("zero-step wait did not end at once");
endmodule
`default_nettype wire

// ---- core/ltb_binning_output.sv ----
// Limit-test binning output port with register access and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ltb_defines.svh"
// Function
// - Patterns are 4 bits; line 4 weight 8 down to line 1 weight 1.
// - Two limit tests, each enabled alone, upper and lower fail patterns.
// - All enabled tests passing drives the programmable pass pattern.
// - Auto-restore holds the result for the programmed width, then idles.
// - A programmable idle pattern sits on the lines between bins.
// - End-strobe mode pulses line 4 to latch lines 1 to 3.
// - Busy modes hold line 4 high or low while a test runs.
// - High-level start begins a test on a high start input.
// - Low-level start begins a test on a low start input.
// - Immediate start tests as soon as testing is enabled.
// - Disabling testing finishes the part under test first.
// - Reset gives fail patterns 15, bounds +1.0 and -1.0, tests off.
// - Each test reports a flag: 0 passed, 1 failed.
// - Immediate clear restores idle; initiate does too when start-clear on.
// - Lines 1 to 3 lead line 4 by 10 us; with auto-restore they also trail it by 10 us.
// - Busy mode forces the idle level of line 4 off; not-busy mode forces it on.
module ltb_binning_output #(
  parameter int STEP_CYCLES = `LTB_STEP_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Measurement
  input wire ltb_pkg::ltb_val_t reading,
  input wire logic readingValid,
  // Handler port
  input wire logic testStartInput,
  output ltb_pkg::ltb_pat_t outLines,
  // Interrupt
  output logic irq
);
  import ltb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ltb_state_e st;
    logic [1:0] sync;
    logic armed;
    logic run;
    logic en1;
    logic en2;
    logic autoRestore;
    logic startClear;
    logic [1:0] armSel;
    logic [1:0] l4Sel;
    logic [23:0] pats;
    logic [22:0] width;
    ltb_val_t up1;
    ltb_val_t lo1;
    ltb_val_t up2;
    ltb_val_t lo2;
    ltb_pat_t result;
    logic fail1;
    logic fail2;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    ltb_pat_t out;
    logic irq;
    logic [31:0] rdata;
    logic load;
    logic [22:0] steps;
    logic [15:0] preCyc;
  } ltb_top_s;

  localparam ltb_top_s RST_S = '{
    st: S_IDLE,
    startClear: 1'b1,
    pats: `LTB_PAT_RST,
    width: `LTB_WIDTH_RST,
    up1: `LTB_UP_RST,
    lo1: `LTB_LO_RST,
    up2: `LTB_UP_RST,
    lo2: `LTB_LO_RST,
    default: '0
  };
  localparam logic [22:0] MAX_STEPS = 23'(`LTB_MAX_STEPS);

  ltb_top_s s, n;
  ltb_if lk();
  logic go, clr, startLvl, showPat, busyNow, l4;
  logic [2:0] ev, w1c;
  ltb_pat_t idlePat;

  function automatic ltb_pat_t patOf(input logic [23:0] p,
    input int idx);
    patOf = p[idx*4 +: 4];
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  assign lk.reading = reading;
  assign lk.up1 = s.up1;
  assign lk.lo1 = s.lo1;
  assign lk.up2 = s.up2;
  assign lk.lo2 = s.lo2;
  assign lk.en1 = s.en1;
  assign lk.en2 = s.en2;
  assign lk.pats = s.pats;
  assign lk.load = s.load;
  assign lk.steps = s.steps;

  ltb_limit_check u_check (
    .lk(lk.cmp)
  );

  ltb_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tm(lk.tmr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    go = 1'b0;
    clr = 1'b0;
    ev = 3'h0;
    w1c = 3'h0;
    showPat = 1'b0;
    busyNow = 1'b0;
    l4 = 1'b0;
    n.load = 1'b0;
    n.sync = {s.sync[0], testStartInput};
    startLvl = (s.armSel == `LTB_ARM_LOW) ? !s.sync[1] : s.sync[1];
    if (s.st == S_PRE) begin
      n.preCyc = s.preCyc + 16'h0001;
    end else begin
      n.preCyc = 16'h0000;
    end
    // Register writes
    if (regWrite) begin
      case (regAddr)
        `LTB_OFS_CTRL: begin
          n.en1 = regWrData[`LTB_C_EN1];
          n.en2 = regWrData[`LTB_C_EN2];
          n.autoRestore = regWrData[`LTB_C_AUTO];
          n.startClear = regWrData[`LTB_C_SCLR];
          n.armSel = regWrData[`LTB_C_ARM +: 2];
          n.l4Sel = regWrData[`LTB_C_L4 +: 2];
          n.run = regWrData[`LTB_C_RUN];
          clr = regWrData[`LTB_C_CLRNOW] |
            (regWrData[`LTB_C_INIT] & regWrData[`LTB_C_SCLR]);
        end
        `LTB_OFS_PAT: n.pats = regWrData[23:0];
        `LTB_OFS_WIDTH: begin
          n.width = (regWrData[22:0] > MAX_STEPS) ? MAX_STEPS :
            regWrData[22:0];
        end
        `LTB_OFS_UP1: n.up1 = regWrData;
        `LTB_OFS_LO1: n.lo1 = regWrData;
        `LTB_OFS_UP2: n.up2 = regWrData;
        `LTB_OFS_LO2: n.lo2 = regWrData;
        `LTB_OFS_IRQ: w1c = regWrData[2:0];
        `LTB_OFS_MASK: n.irqMask = regWrData[2:0];
        default: ;
      endcase
    end
    // Start arming: level must go inactive between parts
    if (!startLvl) begin
      n.armed = 1'b1;
    end
    case (s.st)
      S_IDLE: begin
        if (s.run) begin
          if (s.armSel == `LTB_ARM_IMM) begin
            go = 1'b1;
          end else if (startLvl && s.armed) begin
            go = 1'b1;
          end
        end
        if (go) begin
          n.armed = 1'b0;
          n.st = S_WAIT;
        end
      end
      S_WAIT: begin
        // Runs to the end even if testing is switched off
        if (readingValid) begin
          n.result = lk.verdict;
          n.fail1 = lk.fail1;
          n.fail2 = lk.fail2;
          ev[`LTB_I_DONE] = 1'b1;
          ev[`LTB_I_FAIL] = lk.fail1 | lk.fail2;
          n.load = 1'b1;
          n.steps = 23'h00_0001;
          n.st = S_PRE;
        end
      end
      S_PRE: begin
        // Done from an abandoned wait is ignored while reloading
        if (lk.done && !s.load) begin
          n.st = S_HOLD;
          if (s.autoRestore) begin
            n.load = 1'b1;
            n.steps = s.width;
          end
        end
      end
      S_HOLD: begin
        if (s.autoRestore && lk.done && !s.load) begin
          n.load = 1'b1;
          n.steps = 23'h00_0001;
          n.st = S_POST;
        end
      end
      S_POST: begin
        if (lk.done && !s.load) begin
          ev[`LTB_I_CLR] = 1'b1;
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (clr && (s.st == S_PRE || s.st == S_HOLD || s.st == S_POST)) begin
      ev[`LTB_I_CLR] = 1'b1;
      n.st = S_IDLE;
    end
    // Output lines
    showPat = (n.st == S_PRE || n.st == S_HOLD || n.st == S_POST);
    busyNow = (n.st == S_WAIT);
    idlePat = patOf(n.pats, `LTB_P_IDLE);
    case (n.l4Sel)
      `LTB_L4_BUSY: l4 = busyNow;
      `LTB_L4_NBUSY: l4 = !busyNow;
      default: begin
        l4 = (n.st == S_HOLD) ? n.result[3] : idlePat[3];
      end
    endcase
    n.out = {l4, showPat ? n.result[2:0] : idlePat[2:0]};
    // Interrupts: a new event beats a clear in the same cycle
    n.irqStat = (s.irqStat & ~w1c) | ev;
    n.irq = |(n.irqStat & n.irqMask);
    // Read data stand one cycle after the strobe
    n.rdata = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        `LTB_OFS_CTRL: n.rdata = {23'h00_0000, s.run, s.l4Sel,
          s.armSel, s.startClear, s.autoRestore, s.en2, s.en1};
        `LTB_OFS_PAT: n.rdata = {8'h00, s.pats};
        `LTB_OFS_WIDTH: n.rdata = {9'h000, s.width};
        `LTB_OFS_UP1: n.rdata = s.up1;
        `LTB_OFS_LO1: n.rdata = s.lo1;
        `LTB_OFS_UP2: n.rdata = s.up2;
        `LTB_OFS_LO2: n.rdata = s.lo2;
        `LTB_OFS_STAT: n.rdata = {24'h00_0000, s.out, 1'b0,
          s.st != S_IDLE, s.fail2, s.fail1};
        `LTB_OFS_IRQ: n.rdata = {29'h0000_0000, s.irqStat};
        `LTB_OFS_MASK: n.rdata = {29'h0000_0000, s.irqMask};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  assign outLines = s.out;
  assign irq = s.irq;
  assign regRdData = s.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_reset_defaults: assert property (disable iff (1'b0)
    $fell(sys_rst) |-> s.pats[23:8] == 16'hFFFF && !s.en1 && !s.en2
      && s.up1 == `LTB_UP_RST && s.lo2 == `LTB_LO_RST)
    else $error("reset defaults wrong");
  a_imm_start: assert property (
    s.st == S_IDLE && s.run && s.armSel == `LTB_ARM_IMM
      && !regWrite |=> s.st == S_WAIT)
    else $error("immediate start did not begin");
  a_high_start: assert property (
    s.st == S_IDLE && s.run && s.armSel == `LTB_ARM_HIGH && s.armed
      && s.sync[1] && !regWrite |=> s.st == S_WAIT)
    else $error("high-level start missed");
  a_low_start: assert property (
    s.st == S_IDLE && s.run && s.armSel == `LTB_ARM_LOW && s.armed
      && !s.sync[1] && !regWrite |=> s.st == S_WAIT)
    else $error("low-level start missed");
  a_finish_part: assert property (
    s.st == S_WAIT && !readingValid |=> s.st == S_WAIT)
    else $error("test abandoned before reading");
  a_pass_lines: assert property (
    s.st == S_PRE && !s.fail1 && !s.fail2 && $stable(s.pats)
      |-> outLines[2:0] == s.pats[`LTB_P_PASS*4 +: 3])
    else $error("pass pattern not on lines");
  a_fail_lines: assert property (
    $rose(s.st == S_PRE) && s.fail1 && $stable(s.pats) |->
      s.result == s.pats[`LTB_P_F1U*4 +: 4] ||
      s.result == s.pats[`LTB_P_F1L*4 +: 4])
    else $error("limit 1 fail pattern not chosen");
  a_lead_time: assert property (
    s.st == S_PRE && lk.done && !s.load |-> s.preCyc >= 16'(STEP_CYCLES))
    else $error("lines 1-3 lead line 4 by too little");
  a_idle_lines: assert property (
    s.st == S_IDLE && s.l4Sel == `LTB_L4_EOT
      |-> outLines == patOf(s.pats, `LTB_P_IDLE))
    else $error("idle pattern not on lines");
  a_busy_level: assert property (
    s.st == S_WAIT && s.l4Sel == `LTB_L4_NBUSY |-> !outLines[3])
    else $error("active-low busy not driven");
  a_busy_idle: assert property (
    s.st == S_IDLE && s.l4Sel == `LTB_L4_BUSY |-> !outLines[3])
    else $error("busy idle level of line 4 wrong");
  a_post_restore: assert property (
    s.st == S_POST && lk.done && !regWrite |=> s.st == S_IDLE
      ##1 outLines[2:0] == s.pats[`LTB_P_IDLE*4 +: 3])
    else $error("auto-restore did not return to idle");
  a_clear_now: assert property (
    regWrite && regAddr == `LTB_OFS_CTRL && regWrData[`LTB_C_CLRNOW]
      && s.st == S_HOLD |=> s.st == S_IDLE)
    else $error("immediate clear ignored");
  a_irq_level: assert property (
    s.irqStat[`LTB_I_DONE] && s.irqMask[`LTB_I_DONE]
      && !regWrite |=> irq)
    else $error("interrupt not raised");

  c_pass_bin: cover property (s.st == S_POST && !s.fail1 && !s.fail2);
  c_fail_bin: cover property (s.st == S_HOLD && s.fail2 && !s.fail1);
  c_busy_low: cover property (s.st == S_WAIT && s.l4Sel ==
    `LTB_L4_NBUSY);
  c_early_clear: cover property (s.st == S_HOLD ##1 s.st == S_IDLE
    && !s.autoRestore);
endmodule
`default_nettype wire

// ---- sim/ltb_handler_model.sv ----
// Register-type component handler facing the binning output lines
`timescale 1ns/1ps
`default_nettype none
module ltb_handler_model (
  // Clock
  input wire logic mclk,
  // Bench control
  input wire logic req,
  input wire logic activeLow,
  // Device lines
  input wire ltb_pkg::ltb_pat_t outLines,
  output logic testStartInput,
  output logic [2:0] latched
);
  import ltb_pkg::*;
  logic line4Prev = 1'b0;
  // ----------------------------------------
  // Start request
  // ----------------------------------------
  // Not-ready level is the inverse of the request level
  assign testStartInput = req ^ activeLow;
  // ----------------------------------------
  // Bin latch on rising strobe
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    line4Prev <= outLines[3];
    if (outLines[3] && !line4Prev) begin
      latched <= outLines[2:0];
    end
  end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the binning output block
`timescale 1ns/1ps
`default_nettype none
`include "ltb_defines.svh"
`define CHK(nm, e, g) begin \
  testsRun++; \
  if ((g) !== (e)) begin \
    errCount++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); \
  end \
end
module testbench;
  import ltb_pkg::*;
  localparam int S = 4;
  localparam logic [31:0] EN1 = 32'h0000_0001;
  localparam logic [31:0] EN2 = 32'h0000_0002;
  localparam logic [31:0] AUTO = 32'h0000_0004;
  localparam logic [31:0] SCLR = 32'h0000_0008;
  localparam logic [31:0] RUN = 32'h0000_0100;
  localparam logic [31:0] CLRNOW = 32'h0000_0200;
  localparam logic [31:0] INIT = 32'h0000_0400;
  localparam logic [31:0] PAT = 32'h0065_3A01;
  logic mclk, sys_rst, regWrite, regRead, readingValid, irq;
  logic req, activeLow, testStartInput;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [2:0] latched;
  ltb_val_t reading;
  ltb_pat_t outLines;
  int errCount = 0;
  int testsRun = 0;
  logic [7:0] dA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h30};
  logic [31:0] dE [8] = '{32'h0000_0008, 32'h00FF_FF00, 32'h0000_000A,
    32'h0001_0000, 32'hFFFF_0000, 32'h0001_0000, 32'hFFFF_0000, 32'h0};
  logic [31:0] bC [9] = '{EN1, EN1, EN1 | EN2, EN2, EN2, EN1 | EN2, 32'h0,
    EN1, EN1 | EN2};
  logic [31:0] bR [9] = '{32'h0002_0000, 32'hFFFE_0000, 32'h0,
    32'h0002_0000, 32'hFFFE_0000, 32'h0002_0000, 32'h0002_0000,
    32'h0001_0000, 32'hFFFE_0000};
  logic [3:0] bP [9] = '{4'hA, 4'h3, 4'h1, 4'h5, 4'h6, 4'hA, 4'h1, 4'h1,
    4'h3};
  logic [1:0] bF [9] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h0, 2'h0,
    2'h3};

  ltb_binning_output #(.STEP_CYCLES(S)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .reading(reading),
    .readingValid(readingValid), .testStartInput(testStartInput),
    .outLines(outLines), .irq(irq));
  ltb_handler_model hnd (.mclk(mclk), .req(req), .activeLow(activeLow),
    .outLines(outLines), .testStartInput(testStartInput),
    .latched(latched));

  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic feed(input ltb_val_t v);
    @(posedge mclk);
    reading <= v;
    readingValid <= 1'b1;
    @(posedge mclk);
    readingValid <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic endSim();
    if (errCount == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic hit(input int k);
    case (k)
      0: return outLines[1] === 1'b1;
      1: return outLines[3] === 1'b1;
      2: return outLines[3] === 1'b0;
      default: return outLines === 4'h0;
    endcase
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic checkDefaults();
    logic [31:0] d;
    tick(1);
    `CHK("outLines", 4'h0, outLines)
    for (int i = 0; i < 8; i++) begin
      rd(dA[i], d);
      `CHK("reset value", dE[i], d)
    end
  endtask
  task automatic runTest(input logic [31:0] c, input ltb_val_t v,
      input logic [3:0] p, input logic [1:0] f, input logic useInit);
    logic [31:0] d;
    wr(`LTB_OFS_CTRL, RUN | SCLR | c);
    tick(3);
    feed(v);
    tick(25);
    `CHK("bin", p, outLines)
    rd(`LTB_OFS_STAT, d);
    `CHK("flags", f, d[1:0])
    `CHK("stat lines", p, d[7:4])
    wr(`LTB_OFS_CTRL, useInit ? (SCLR | INIT) : CLRNOW);
    tick(3);
    `CHK("restore", 4'h0, outLines)
  endtask
  task automatic checkBins();
    wr(`LTB_OFS_PAT, PAT);
    for (int i = 0; i < 9; i++) begin
      runTest(bC[i], bR[i], bP[i], bF[i], 1'b0);
    end
  endtask
  task automatic checkAuto();
    int t[4];
    int k;
    logic [31:0] d;
    k = 0;
    wr(`LTB_OFS_WIDTH, 32'h007F_FFFF);
    rd(`LTB_OFS_WIDTH, d);
    `CHK("width clamp", 32'(`LTB_MAX_STEPS), d)
    wr(`LTB_OFS_WIDTH, 32'h0000_0002);
    wr(`LTB_OFS_CTRL, RUN | AUTO | EN1 | SCLR);
    tick(2);
    wr(`LTB_OFS_CTRL, AUTO | EN1 | SCLR);
    feed(32'h0002_0000);
    for (int i = 0; i < 200; i++) begin
      tick(1);
      if (k < 4 && hit(k)) begin
        t[k] = i;
        k++;
      end
    end
    `CHK("phases", 4, k)
    `CHK("lead", 1'b1, t[1] - t[0] >= S && t[1] - t[0] <= S + 3)
    `CHK("hold", 1'b1, t[2] - t[1] >= 2 * S && t[2] - t[1] <= 2 * S + 3)
    `CHK("trail", 1'b1, t[3] - t[2] >= S && t[3] - t[2] <= S + 3)
  endtask
  task automatic checkBusy();
    logic [31:0] l4;
    for (int m = 1; m <= 2; m++) begin
      l4 = 32'(m << 6);
      wr(`LTB_OFS_PAT, (m == 1) ? 32'h0065_3A81 : PAT);
      wr(`LTB_OFS_CTRL, SCLR | EN1 | l4);
      tick(3);
      `CHK("idle line4", m == 2, outLines[3])
      wr(`LTB_OFS_CTRL, RUN | SCLR | EN1 | l4);
      tick(3);
      `CHK("busy line4", m == 1, outLines[3])
      wr(`LTB_OFS_CTRL, SCLR | EN1 | l4);
      feed(32'h0);
      tick(25);
      `CHK("done line4", m == 2, outLines[3])
      wr(`LTB_OFS_CTRL, CLRNOW | l4);
    end
    wr(`LTB_OFS_PAT, PAT);
    wr(`LTB_OFS_CTRL, SCLR);
  endtask
  task automatic checkStarts();
    logic [31:0] d;
    logic [31:0] c;
    for (int p = 1; p <= 2; p++) begin
      c = SCLR | EN1 | 32'(p << 4);
      @(posedge mclk);
      activeLow <= (p == 2);
      wr(`LTB_OFS_CTRL, RUN | c);
      tick(6);
      rd(`LTB_OFS_STAT, d);
      `CHK("no start", 1'b0, d[2])
      @(posedge mclk);
      req <= 1'b1;
      tick(6);
      rd(`LTB_OFS_STAT, d);
      `CHK("started", 1'b1, d[2])
      wr(`LTB_OFS_CTRL, c);
      feed(32'h0002_0000);
      @(posedge mclk);
      req <= 1'b0;
      tick(25);
      `CHK("finished", 4'hA, outLines)
      `CHK("latched", 3'h2, latched)
      wr(`LTB_OFS_CTRL, CLRNOW | c);
      @(posedge mclk);
      req <= 1'b1;
      tick(8);
      rd(`LTB_OFS_STAT, d);
      `CHK("stopped", 1'b0, d[2])
      @(posedge mclk);
      req <= 1'b0;
    end
  endtask
  task automatic checkIrq();
    logic [31:0] d;
    wr(`LTB_OFS_MASK, 32'h0);
    wr(`LTB_OFS_IRQ, 32'h0000_0007);
    runTest(EN1, 32'h0002_0000, 4'hA, 2'h1, 1'b1);
    `CHK("masked irq", 1'b0, irq)
    wr(`LTB_OFS_MASK, 32'h0000_0001);
    tick(3);
    `CHK("irq", 1'b1, irq)
    rd(`LTB_OFS_IRQ, d);
    `CHK("events", 3'h7, d[2:0])
    wr(`LTB_OFS_IRQ, 32'h0000_0007);
    tick(3);
    `CHK("irq cleared", 1'b0, irq)
    rd(`LTB_OFS_IRQ, d);
    `CHK("events cleared", 3'h0, d[2:0])
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errCount++;
    endSim();
  end
  initial begin
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    reading = 32'h0;
    readingValid = 1'b0;
    req = 1'b0;
    activeLow = 1'b0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    checkDefaults();
    checkBins();
    checkAuto();
    checkBusy();
    checkStarts();
    checkIrq();
    endSim();
  end
endmodule
`default_nettype wire
